/* logic/intc_cfg_pkg.sv */
package intc_cfg_pkg;

  // Register map (byte addresses, one aligned word each)
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] stat_addr = 4'h4;
  localparam logic [3:0] clr_addr = 4'h8;
  localparam logic [3:0] ien_addr = 4'hC;
  localparam int addr_width = 4;
  localparam int num_ext = 5;
  localparam int prio_width = 3;

  // Control register field positions
  localparam int vec_mode_bit = 12;
  localparam int prox_lsb = 8;
  localparam int prox_msb = 10;
  localparam int edge_lsb = 0;

  // Control register reset value and writable-bit mask
  localparam logic [31:0] ctrl_reset = 32'h0000_0000;
  localparam logic [31:0] ctrl_mask = 32'h0000_171F;
  localparam logic [2:0] prox_off = 3'h0;
  localparam logic [2:0] prox_only_one = 3'h1;
  localparam logic [2:0] prio_one = 3'h1;

  // AXI4-Lite responses
  localparam logic [1:0] resp_okay = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;

  // Proximity hold time, 1 us at 125 MHz
  localparam int prox_hold_ns = 1000;
  localparam int clk_period_ns = 8;
  localparam int prox_hold_cycles = prox_hold_ns / clk_period_ns;
  localparam int prox_cnt_width = 8;

  // Decoded control register fields; only edge_sel is carried to the edge unit
  typedef struct packed {
    logic vector_mode_select;
    logic [2:0] proximity_timer_priority;
    logic [4:0] edge_sel;
  } cfg_type;

endpackage

/* logic/ext_edge_detect.sv */
`timescale 1ns/1ps
module ext_edge_detect (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pins and polarity
  input wire logic [intc_cfg_pkg::num_ext-1:0] ext_irq,
  input wire logic [intc_cfg_pkg::num_ext-1:0] edge_sel,
  // Detected edges
  output logic [intc_cfg_pkg::num_ext-1:0] edge_pulse
);

  logic [intc_cfg_pkg::num_ext-1:0] sync1_q;
  logic [intc_cfg_pkg::num_ext-1:0] sync2_q;
  logic [intc_cfg_pkg::num_ext-1:0] prev_q;
  logic [intc_cfg_pkg::num_ext-1:0] pulse_q;

  // Per-input synchroniser and polarity-selected edge detector
  genvar i;
  generate
    for (i = 0; i < intc_cfg_pkg::num_ext; i++)
    begin : g_ch
      wire rise = sync2_q[i] & ~prev_q[i];
      wire fall = ~sync2_q[i] & prev_q[i];
      wire hit = edge_sel[i] ? rise : fall;
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1_q[i] <= 1'b0;
          sync2_q[i] <= 1'b0;
          prev_q[i] <= 1'b0;
          pulse_q[i] <= 1'b0;
        end
        else
        begin
          sync1_q[i] <= ext_irq[i];
          sync2_q[i] <= sync1_q[i];
          prev_q[i] <= sync2_q[i];
          pulse_q[i] <= hit;
        end
      end
    end
  endgenerate

  assign edge_pulse = pulse_q;

endmodule

/* logic/interrupt_control_config.sv */
`timescale 1ns/1ps
// Summary of operation
// - Control bit 12 set selects multi-vectored dispatch, clear selects single-vectored.
// - Bits 10..8 hold the proximity priority field; zero turns the proximity timer off.
// - A field of 1 starts the timer only for group priority 1 interrupts.
// - A field of 2..7 starts the timer for any group priority at or below the field.
// - Polarity bits for external inputs 0..4 sit at control bits 0..4.
// - Unimplemented control bits read as zero and ignore writes.
// - All control bits reset to zero: single vector, timer off, falling edges.
module interrupt_control_config (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [intc_cfg_pkg::addr_width-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [intc_cfg_pkg::addr_width-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External interrupt pins
  input wire logic [intc_cfg_pkg::num_ext-1:0] ext_irq,
  // Group priority of each external source
  input wire logic [intc_cfg_pkg::num_ext*intc_cfg_pkg::prio_width-1:0] ext_prio,
  // Core side
  output logic [intc_cfg_pkg::num_ext-1:0] core_req,
  output logic vector_mode_select,
  output logic irq
);

  localparam int n = intc_cfg_pkg::num_ext;
  localparam int pw = intc_cfg_pkg::prio_width;
  localparam int cw = intc_cfg_pkg::prox_cnt_width;
  localparam logic [cw-1:0] hold_count = cw'(intc_cfg_pkg::prox_hold_cycles);
  localparam logic [cw-1:0] cnt_zero = '0;
  localparam logic [cw-1:0] cnt_one = cw'(1);

  intc_cfg_pkg::cfg_type cfg;
  logic [31:0] ctrl_q;
  logic [n-1:0] stat_q;
  logic [n-1:0] ien_q;
  logic [n-1:0] pend_q;
  logic [n-1:0] req_q;
  logic [cw-1:0] prox_cnt_q;
  logic vec_q;
  logic irq_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [intc_cfg_pkg::addr_width-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_held_q;
  logic w_held_q;
  logic [n-1:0] edge_pulse;

  // Field view of the control register
  assign cfg.vector_mode_select = ctrl_q[intc_cfg_pkg::vec_mode_bit];
  assign cfg.proximity_timer_priority =
    ctrl_q[intc_cfg_pkg::prox_msb:intc_cfg_pkg::prox_lsb];
  assign cfg.edge_sel = ctrl_q[intc_cfg_pkg::edge_lsb +: n];

  // Synchronised edge detection of the pins
  ext_edge_detect u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ext_irq(ext_irq),
    .edge_sel(cfg.edge_sel),
    .edge_pulse(edge_pulse)
  );

  // Write channel: address and data may arrive in either order
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire aw_have = aw_held_q | aw_take;
  wire w_have = w_held_q | w_take;
  wire [intc_cfg_pkg::addr_width-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0] wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;
  wire wr_fire = aw_have & w_have & ~bvalid_q;
  wire [31:0] strb_mask = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire wr_ctrl = wr_fire & (wr_addr == intc_cfg_pkg::ctrl_addr);
  wire wr_clr = wr_fire & (wr_addr == intc_cfg_pkg::clr_addr);
  wire wr_ien = wr_fire & (wr_addr == intc_cfg_pkg::ien_addr);
  wire wr_ro = wr_fire & (wr_addr == intc_cfg_pkg::stat_addr);
  wire wr_hit = wr_ctrl | wr_clr | wr_ien | wr_ro;
  wire [31:0] wmask = strb_mask & intc_cfg_pkg::ctrl_mask;
  wire [31:0] ctrl_d = (ctrl_q & ~wmask) | (wr_data & wmask);
  wire [n-1:0] low_mask = strb_mask[n-1:0];
  wire [n-1:0] clr_bits = wr_clr ? (wr_data[n-1:0] & low_mask) : '0;
  wire [n-1:0] ien_d = (ien_q & ~low_mask) | (wr_data[n-1:0] & low_mask);

  // Read decode; unmapped addresses answer SLVERR with zero data
  wire rd_take = s_axi_arvalid & arready_q;
  wire rd_ctrl = s_axi_araddr == intc_cfg_pkg::ctrl_addr;
  wire rd_stat = s_axi_araddr == intc_cfg_pkg::stat_addr;
  wire rd_clr = s_axi_araddr == intc_cfg_pkg::clr_addr;
  wire rd_ien = s_axi_araddr == intc_cfg_pkg::ien_addr;
  wire [31:0] rd_val = rd_ctrl ? (ctrl_q & intc_cfg_pkg::ctrl_mask) :
                       rd_stat ? {{(32-n){1'b0}}, stat_q} :
                       rd_ien ? {{(32-n){1'b0}}, ien_q} : 32'h0000_0000;
  wire rd_ok = rd_ctrl | rd_stat | rd_clr | rd_ien;

  // Proximity eligibility per source
  logic [n-1:0] elig;
  genvar g;
  generate
    for (g = 0; g < n; g++)
    begin : g_elig
      wire [pw-1:0] p = ext_prio[g*pw +: pw];
      wire only_one = (cfg.proximity_timer_priority == intc_cfg_pkg::prox_only_one) &
                      (p == intc_cfg_pkg::prio_one);
      wire at_below = (cfg.proximity_timer_priority > intc_cfg_pkg::prox_only_one) &
                      (p <= cfg.proximity_timer_priority);
      assign elig[g] = (cfg.proximity_timer_priority != intc_cfg_pkg::prox_off) &
                       (only_one | at_below);
    end
  endgenerate

  // Held requests flush when the timer expires or the timer is switched off
  wire prox_active = prox_cnt_q != cnt_zero;
  wire prox_expire = prox_cnt_q == cnt_one;
  wire [n-1:0] new_pend = edge_pulse & elig;
  wire [n-1:0] direct = edge_pulse & ~elig;
  wire flush = prox_expire | (cfg.proximity_timer_priority == intc_cfg_pkg::prox_off);
  wire [n-1:0] release_now = flush ? pend_q : '0;
  wire [n-1:0] pend_d = (pend_q & ~release_now) | new_pend;
  // Reload on expiry too, or an edge landing on the last count would stay pending
  wire start_prox = (|new_pend) & (~prox_active | prox_expire);
  wire [cw-1:0] prox_cnt_d = start_prox ? hold_count :
                             prox_active ? prox_cnt_q - cnt_one : cnt_zero;
  wire [n-1:0] stat_d = (stat_q & ~clr_bits) | edge_pulse; // Set wins over clear

  // Control register; unimplemented bits never load
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_q <= intc_cfg_pkg::ctrl_reset;
    else if (wr_ctrl)
      ctrl_q <= ctrl_d;
  end

  // Interrupt status, enable and output level
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat_q <= '0;
      ien_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      ien_q <= wr_ien ? ien_d : ien_q;
      irq_q <= |(stat_d & (wr_ien ? ien_d : ien_q));
    end
  end

  // Proximity timer and request delivery to the core
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pend_q <= '0;
      prox_cnt_q <= cnt_zero;
      req_q <= '0;
      vec_q <= 1'b0;
    end
    else
    begin
      pend_q <= pend_d;
      prox_cnt_q <= prox_cnt_d;
      req_q <= direct | release_now;
      vec_q <= cfg.vector_mode_select;
    end
  end

  // Write handshake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= intc_cfg_pkg::resp_okay;
    end
    else
    begin
      aw_held_q <= aw_have & ~wr_fire;
      w_held_q <= w_have & ~wr_fire;
      if (aw_take)
        awaddr_q <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      awready_q <= ~aw_have & ~wr_fire & ~bvalid_q & ~awready_q;
      wready_q <= ~w_have & ~wr_fire & ~bvalid_q & ~wready_q;
      if (wr_fire)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? intc_cfg_pkg::resp_okay : intc_cfg_pkg::resp_slverr;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // Read handshake state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= intc_cfg_pkg::resp_okay;
    end
    else
    begin
      arready_q <= ~arready_q & ~rvalid_q & ~rd_take;
      if (rd_take)
      begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_ok ? intc_cfg_pkg::resp_okay : intc_cfg_pkg::resp_slverr;
      end
      else if (s_axi_rready)
        rvalid_q <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign core_req = req_q;
  assign vector_mode_select = vec_q;
  assign irq = irq_q;

endmodule

/* verif/intc_cfg_monitor.sv */
`timescale 1ns/1ps
module intc_cfg_monitor (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire logic [4:0] core_req,
  input wire logic vector_mode_select
);
  logic [3:0] wa_q;
  logic [3:0] ra_q;

  // Keep taken addresses so each answer is judged against its request
  always_ff @(posedge aclk)
  begin
    if (s_axi_awvalid && s_axi_awready)
      wa_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready)
      ra_q <= s_axi_araddr;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Request phases
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  a_write_answer: assert property (wr_taken |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data dropped");
  a_no_read_overlap: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  a_unimpl_zero: assert property (
    s_axi_rvalid && ra_q == intc_cfg_pkg::ctrl_addr |->
    (s_axi_rdata & ~intc_cfg_pkg::ctrl_mask) == 32'h0) else $error("unused bits set");
  a_unmapped_err: assert property (s_axi_bvalid && wa_q[1:0] != 2'h0 |->
    s_axi_bresp == intc_cfg_pkg::resp_slverr) else $error("unmapped write accepted");
  a_vec_follow: assert property ($changed(vector_mode_select) |->
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("mode moved alone");
  a_req_pulse: assert property (core_req != 5'h0 |=>
    (core_req & $past(core_req)) == 5'h0) else $error("request longer than a pulse");
endmodule

/* verif/core_model.sv */
`timescale 1ns/1ps
module core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests from the controller
  input wire logic [4:0] core_req,
  // Delivered requests, one count per source
  output logic [4:0][7:0] req_cnt
);
  // The core takes every pulse at once; counts expose lost or extra ones
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      req_cnt <= '0;
    else
      for (int i = 0; i < 5; i++)
        req_cnt[i] <= req_cnt[i] + 8'(core_req[i]);
  end
endmodule

/* verif/interrupt_control_config_tb_top.sv */
`timescale 1ns/1ps
module interrupt_control_config_tb_top;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [4:0] ext_irq, core_req, el;
  logic [14:0] ext_prio;
  logic vector_mode_select, irq;
  logic [4:0][7:0] req_cnt;
  logic [7:0] ex [5];
  int err_total, comparisons;

  interrupt_control_config dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .ext_irq, .ext_prio, .core_req, .vector_mode_select, .irq);
  core_model core (.aclk, .aresetn, .core_req, .req_cnt);

  // Clock, 8 ns period
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task results;
    if (err_total == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // Address and data offered together, each dropped once taken
  // Response ready comes late so the slave must hold its answer a cycle
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask

  task rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask

  // Pins move, then the synchroniser gets time to settle
  task pins(input logic [4:0] v);
    @(posedge aclk);
    ext_irq <= v;
    repeat (12) @(posedge aclk);
  endtask

  task cmpc;
    for (int j = 0; j < 5; j++)
      chk("req_cnt", 32'(ex[j]), 32'(req_cnt[j]));
  endtask

  task irq_is(input logic v);
    repeat (3) @(posedge aclk);
    chk("irq", 32'(v), 32'(irq));
  endtask

  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_irq} = '0;
    s_axi_wstrb = 4'hF;
    ext_prio = 15'b111_000_011_010_001;
    err_total = 0;
    comparisons = 0;
    for (int j = 0; j < 5; j++)
      ex[j] = 8'h00;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(intc_cfg_pkg::ctrl_addr, 32'h0, 2'h0);
    wr(intc_cfg_pkg::ctrl_addr, 32'hFFFF_FFFF, 2'h0);
    rd(intc_cfg_pkg::ctrl_addr, 32'h0000_171F, 2'h0);
    repeat (3) @(posedge aclk);
    chk("vector_mode_select", 32'h1, 32'(vector_mode_select));
    wr(intc_cfg_pkg::ctrl_addr, 32'h0, 2'h0);
    repeat (3) @(posedge aclk);
    chk("vector_mode_select", 32'h0, 32'(vector_mode_select));
    wr(4'h6, 32'h1, 2'h2);
    rd(4'h6, 32'h0, 2'h2);
    // One pin rising, the rest falling, in turn
    for (int i = 0; i < 5; i++)
    begin
      wr(intc_cfg_pkg::ctrl_addr, 32'h1 << i, 2'h0);
      pins(5'h1F);
      ex[i]++;
      cmpc();
      pins(5'h00);
      for (int j = 0; j < 5; j++)
        if (j != i)
          ex[j]++;
      cmpc();
    end
    rd(intc_cfg_pkg::stat_addr, 32'h1F, 2'h0);
    irq_is(1'b0);
    wr(intc_cfg_pkg::ien_addr, 32'h1F, 2'h0);
    rd(intc_cfg_pkg::ien_addr, 32'h1F, 2'h0);
    irq_is(1'b1);
    wr(intc_cfg_pkg::clr_addr, 32'h1F, 2'h0);
    rd(intc_cfg_pkg::stat_addr, 32'h0, 2'h0);
    rd(intc_cfg_pkg::clr_addr, 32'h0, 2'h0);
    irq_is(1'b0);
    // Every proximity code; held sources must wait, the others pass at once
    for (int f = 0; f < 8; f++)
    begin
      for (int j = 0; j < 5; j++)
        el[j] = (f == 1) ? (ext_prio[3*j +: 3] == 3'h1) : (f >= 2 && ext_prio[3*j +: 3] <= f);
      wr(intc_cfg_pkg::ctrl_addr, 32'(f << 8) | 32'h1F, 2'h0);
      pins(5'h1F);
      for (int j = 0; j < 5; j++)
        ex[j] += 8'(!el[j]);
      cmpc();
      repeat (140) @(posedge aclk);
      for (int j = 0; j < 5; j++)
        ex[j] += 8'(el[j]);
      cmpc();
      pins(5'h00);
    end
    results();
  end

  // Hang guard, well past the expected run length
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    results();
  end
endmodule

bind interrupt_control_config intc_cfg_monitor mon (.aclk, .aresetn, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .core_req, .vector_mode_select);
